// ### rtl/fgm_cmd_map.sv
// Two-wire target and standard command map of the fuel gauge.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Each command is a 16-bit word moved as low byte then high byte.
// R2: A command is picked by its even code, the odd code names its high byte.
// R3: Host sends the command code, then moves the two data bytes.
// R4: Commands take effect only in normal power mode; else reads give zero.
// R5: Locked state blocks unlocked-only control subcommands.
// R6: Control word at 0x00/0x01 is readable and writable even when locked.
// R7: Temperature word at 0x02/0x03 is readable and writable when locked.
// R8: Cell voltage at 0x04/0x05 is read-only.
// R9: Gauge condition word at 0x06/0x07 is read-only.
// R10: Four capacity words at 0x08 to 0x0F are read-only.
// R11: Three current words at 0x10 to 0x15 are read-only.
// R12: Energy at 0x16/0x17 and power at 0x18/0x19 are read-only.
// R13: Charge percentage at 0x1C/0x1D is read-only.
// R14: Internal temperature at 0x1E/0x1F is read-only.
// R15: State of health at 0x20/0x21 is read-only.
// R16: A host-written temperature replaces the internal sensor reading.
// R17: Power modes move on internal events; host may request some modes.
// R18: Commands give the host access to control and status words.
// R19: After selecting the control word the host writes a subcommand.
// R20: Writes to read-only or unassigned codes have no effect.
module fgm_cmd_map
    import fgm_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Two-wire link pins.
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output var  logic        sda_o,
    output var  logic        sda_oe,
    // Measurements from the gauge core.
    input  wire logic [15:0] cell_potential_i,
    input  wire logic [15:0] cond_i,
    input  wire logic [15:0] nomav_i,
    input  wire logic [15:0] fulav_i,
    input  wire logic [15:0] rmc_i,
    input  wire logic [15:0] fulch_i,
    input  wire logic [15:0] meani_i,
    input  wire logic [15:0] stbyi_i,
    input  wire logic [15:0] maxi_i,
    input  wire logic [15:0] energy_i,
    input  wire logic [15:0] power_i,
    input  wire logic [15:0] charge_i,
    input  wire logic [15:0] intmp_i,
    input  wire logic [15:0] health_i,
    // Events from the gauge core.
    input  wire logic        init_done,
    input  wire logic        sleep_cond,
    input  wire logic        wake_evt,
    input  wire logic        unlock_req,
    // Results towards the gauge core.
    output var  logic [15:0] subcmd,
    output var  logic        subcmd_stb,
    output var  logic [15:0] temp_used,
    output var  logic        locked_state,
    output var  logic        hib_req,
    output var  fgm_mode_t   power_mode
);

    fgm_state_t  st_q;
    fgm_state_t  st_d;
    logic        rst_m_q;
    logic        rst_s_q;
    logic        start_c;
    logic        stop_c;
    logic        hit_c;
    logic        commit_c;
    logic [7:0]  commit_ptr_c;
    logic [15:0] commit_word_c;

    // Reset is released through two flops so that removal is clean.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    // Word seen by a read; outside normal mode every read shows zero.
    function automatic logic [15:0] rd_word(input logic [7:0] a);
        logic [15:0] s;
        s = 16'h0000;
        s[ST_HIBE]  = (st_q.mode == PM_HIB);
        s[ST_LOCK]  = st_q.locked;
        s[ST_INIT]  = (st_q.mode != PM_INIT);
        s[ST_HIB]   = st_q.hib_req;
        s[ST_DEEP]  = st_q.deep_req;
        s[ST_SLEEP] = (st_q.mode == PM_SLEEP);
        if (st_q.mode != PM_NORMAL) begin // R4
            return 16'h0000;
        end
        case (a) // R2 R18
            CMD_CONTROL: begin // R6
                if (st_q.ctrl == SUB_STATUS) begin
                    return s;
                end else if (st_q.ctrl == SUB_PREV && !st_q.locked) begin
                    return st_q.prev;
                end else begin
                    return st_q.ctrl;
                end
            end
            CMD_TEMP:   return st_q.temp_out; // R7
            CMD_CELL_POTENTIAL:   return cell_potential_i; // R8
            CMD_COND:   return cond_i; // R9
            CMD_NOMAV:  return nomav_i; // R10
            CMD_FULAV:  return fulav_i;
            CMD_RMC:    return rmc_i;
            CMD_FULCH:  return fulch_i;
            CMD_MEANI:  return meani_i; // R11
            CMD_STBYI:  return stbyi_i;
            CMD_MAXI:   return maxi_i;
            CMD_ENERGY: return energy_i; // R12
            CMD_POWER:  return power_i;
            CMD_CHARGE: return charge_i; // R13
            CMD_INTMP:  return intmp_i; // R14
            CMD_HEALTH: return health_i; // R15
            default:    return 16'h0000; // R20
        endcase
    endfunction

    // Next state: pin sampling, link sequencing, command map and power modes.
    always_comb begin
        logic       rise;
        logic       fall;
        logic       load;
        logic       wr;
        logic [7:0] b;
        logic [15:0] w;
        rise = 1'b0;
        fall = 1'b0;
        load = 1'b0;
        wr   = 1'b0;
        b    = 8'h00;
        w    = 16'h0000;
        st_d = st_q;
        hit_c = 1'b0;
        commit_c = 1'b0;
        commit_ptr_c = 8'h00;
        commit_word_c = 16'h0000;
        st_d.stb = 1'b0;
        st_d.sda_o = 1'b0;
        // Pins pass three flops; only the second and third stages feed any logic.
        st_d.scl_m = scl_i;
        st_d.scl_s = st_q.scl_m;
        st_d.scl_p = st_q.scl_s;
        st_d.sda_m = sda_i;
        st_d.sda_s = st_q.sda_m;
        st_d.sda_p = st_q.sda_s;
        start_c = st_q.scl_s & st_q.scl_p & st_q.sda_p & ~st_q.sda_s;
        stop_c  = st_q.scl_s & st_q.scl_p & ~st_q.sda_p & st_q.sda_s;
        rise = st_q.scl_s & ~st_q.scl_p;
        fall = ~st_q.scl_s & st_q.scl_p;

        // Link sequencing; a start or stop aborts whatever byte is in flight.
        if (start_c) begin
            st_d.phase = BS_ADDR;
            st_d.cnt = 3'h0;
            st_d.sda_oe = 1'b0;
        end else if (stop_c) begin
            st_d.phase = BS_IDLE;
            st_d.sda_oe = 1'b0;
        end else begin
            case (st_q.phase)
                BS_ADDR: begin
                    if (rise) begin
                        b = {st_q.sh[6:0], st_q.sda_s};
                        st_d.sh = b;
                        st_d.cnt = st_q.cnt + 3'h1;
                        if (st_q.cnt == BIT_LAST) begin
                            st_d.phase = BS_AACK;
                            st_d.ack_drv = 1'b0;
                            st_d.hit = (b[7:1] == DEV_ADDR);
                            st_d.rw = b[0];
                            st_d.first = ~b[0]; // R3
                            hit_c = (b[7:1] == DEV_ADDR);
                        end
                    end
                end
                BS_AACK, BS_WACK: begin
                    if (fall && !st_q.ack_drv) begin
                        st_d.ack_drv = 1'b1;
                        st_d.sda_oe = st_q.hit;
                    end else if (fall) begin
                        st_d.ack_drv = 1'b0;
                        st_d.sda_oe = 1'b0;
                        st_d.cnt = 3'h0;
                        if (!st_q.hit) begin
                            st_d.phase = BS_IDLE;
                        end else if (st_q.phase == BS_AACK && st_q.rw) begin
                            load = 1'b1;
                        end else begin
                            st_d.phase = BS_WR;
                        end
                    end
                end
                BS_WR: begin
                    if (rise) begin
                        b = {st_q.sh[6:0], st_q.sda_s};
                        st_d.sh = b;
                        st_d.cnt = st_q.cnt + 3'h1;
                        if (st_q.cnt == BIT_LAST) begin
                            st_d.phase = BS_WACK;
                            st_d.ack_drv = 1'b0;
                            st_d.hit = 1'b1;
                            if (st_q.first) begin
                                st_d.ptr = b; // R3
                                st_d.first = 1'b0;
                                st_d.wlo_ok = 1'b0;
                            end else begin
                                wr = 1'b1;
                            end
                        end
                    end
                end
                BS_RD: begin
                    if (rise) begin
                        st_d.cnt = st_q.cnt + 3'h1;
                        if (st_q.cnt == BIT_LAST) begin
                            st_d.phase = BS_RACK;
                            st_d.ack_drv = 1'b0;
                        end
                    end else if (fall) begin
                        st_d.sh = {st_q.sh[6:0], 1'b0};
                        st_d.sda_oe = ~st_q.sh[6];
                    end
                end
                BS_RACK: begin
                    if (fall && !st_q.ack_drv) begin
                        st_d.sda_oe = 1'b0;
                        st_d.ack_drv = 1'b1;
                    end else if (rise && st_q.ack_drv) begin
                        st_d.hit = ~st_q.sda_s;
                        if (!st_q.sda_s) begin
                            st_d.ptr = st_q.ptr + 8'h01;
                        end
                    end else if (fall) begin
                        st_d.ack_drv = 1'b0;
                        if (st_q.hit) begin
                            load = 1'b1;
                        end else begin
                            st_d.phase = BS_IDLE;
                        end
                    end
                end
                default: st_d.phase = BS_IDLE;
            endcase
        end

        // Even byte of a read snapshots the word so both halves agree.
        if (load) begin
            w = rd_word({st_q.ptr[7:1], 1'b0});
            if (!st_q.ptr[0]) begin // R1
                st_d.snap = w;
                st_d.snap_ptr = st_q.ptr;
                b = w[7:0];
            end else if (st_q.snap_ptr == {st_q.ptr[7:1], 1'b0}) begin
                b = st_q.snap[15:8];
            end else begin
                b = w[15:8];
            end
            st_d.phase = BS_RD;
            st_d.sh = b;
            st_d.sda_oe = ~b[7];
            st_d.cnt = 3'h0;
        end

        // Low byte waits; the high byte commits the whole word at once.
        if (wr) begin
            st_d.ptr = st_q.ptr + 8'h01;
            if (!st_q.ptr[0]) begin // R1 R2
                st_d.wlo = b;
                st_d.wlo_ptr = st_q.ptr;
                st_d.wlo_ok = 1'b1;
            end else if (st_q.wlo_ok && st_q.wlo_ptr == {st_q.ptr[7:1], 1'b0}) begin
                st_d.wlo_ok = 1'b0;
                commit_c = (st_q.mode == PM_NORMAL); // R4
                commit_ptr_c = st_q.wlo_ptr;
                commit_word_c = {b, st_q.wlo};
            end
        end

        // Power modes; clears here come before the sets further down.
        case (st_q.mode) // R17
            PM_INIT: begin
                if (init_done) begin
                    st_d.mode = PM_NORMAL;
                end
            end
            PM_NORMAL: begin
                if (sleep_cond) begin
                    st_d.mode = PM_SLEEP;
                end
            end
            PM_SLEEP: begin
                if (hit_c || !sleep_cond) begin
                    st_d.mode = PM_NORMAL;
                end else if (st_q.hib_req) begin
                    st_d.mode = PM_HIB;
                end else if (st_q.deep_req) begin
                    st_d.mode = PM_DEEP;
                end
            end
            PM_DEEP: begin
                if (hit_c) begin
                    st_d.mode = PM_SLEEP;
                    st_d.deep_req = 1'b0;
                end
            end
            PM_HIB: begin
                if (wake_evt) begin
                    st_d.mode = PM_SLEEP;
                    st_d.hib_req = 1'b0;
                end
            end
            default: st_d.mode = PM_INIT;
        endcase

        if (unlock_req) begin
            st_d.locked = 1'b0;
        end

        // Word commits; read-only and unassigned codes fall through untouched.
        if (commit_c) begin
            case (commit_ptr_c)
                CMD_CONTROL: begin // R6 R19
                    if (!(st_q.locked && (commit_word_c == SUB_RESTORE ||
                          commit_word_c == SUB_LOCK || commit_word_c == SUB_RESET ||
                          commit_word_c == SUB_PREV))) begin // R5
                        st_d.ctrl = commit_word_c;
                        st_d.stb = 1'b1;
                        if (commit_word_c < SUB_RESTORE && commit_word_c != SUB_PREV) begin
                            st_d.prev = commit_word_c;
                        end
                        case (commit_word_c) // R17
                            SUB_LOCK:    st_d.locked = 1'b1;
                            SUB_DEEP:    st_d.deep_req = 1'b1;
                            SUB_SET_HIB: st_d.hib_req = 1'b1;
                            SUB_CLR_HIB: st_d.hib_req = 1'b0;
                            default:     st_d.deep_req = st_d.deep_req;
                        endcase
                    end
                end
                CMD_TEMP: begin // R7 R16
                    st_d.host_temp = commit_word_c;
                    st_d.host_sel = 1'b1;
                end
                default: st_d.ctrl = st_d.ctrl; // R20
            endcase
        end

        // Host value wins once written; the sensor is only the fallback.
        st_d.temp_out = st_q.host_sel ? st_q.host_temp : intmp_i; // R16
    end

    // All state in one register, reset to idle and to the locked state.
    always_ff @(posedge mclk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            st_q <= '0;
            st_q.locked <= LOCK_AT_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register.
    assign sda_o        = st_q.sda_o;
    assign sda_oe       = st_q.sda_oe;
    assign subcmd       = st_q.ctrl;
    assign subcmd_stb   = st_q.stb;
    assign temp_used    = st_q.temp_out;
    assign locked_state = st_q.locked;
    assign hib_req      = st_q.hib_req;
    assign power_mode   = st_q.mode;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_s_q);

    property p_lock_sub;
        commit_c && !st_q.locked && commit_ptr_c == CMD_CONTROL && commit_word_c == SUB_LOCK
            |=> locked_state && subcmd_stb ##1 !subcmd_stb;
    endproperty
    a_lock_sub: assert property (p_lock_sub) else $error("lock subcommand not applied"); // R5

    property p_locked_filter;
        $past(st_q.locked) && subcmd_stb |-> subcmd != SUB_RESET && subcmd != SUB_RESTORE;
    endproperty
    a_locked_filter: assert property (p_locked_filter) else $error("locked passed subcommand"); // R5

    property p_normal_only;
        st_q.mode != PM_NORMAL |=> !subcmd_stb && $stable(st_q.host_temp);
    endproperty
    a_normal_only: assert property (p_normal_only) else $error("write outside normal mode"); // R4

    property p_host_temp;
        commit_c && commit_ptr_c == CMD_TEMP |-> ##2 temp_used == $past(commit_word_c, 2);
    endproperty
    a_host_temp: assert property (p_host_temp) else $error("host temperature not used"); // R16

    property p_ro_ignored;
        commit_c && commit_ptr_c != CMD_CONTROL && commit_ptr_c != CMD_TEMP
            |=> !subcmd_stb && $stable(st_q.host_temp) && $stable(subcmd);
    endproperty
    a_ro_ignored: assert property (p_ro_ignored) else $error("read-only write had effect"); // R20

    property p_init_exit;
        st_q.mode == PM_INIT && init_done |=> power_mode == PM_NORMAL;
    endproperty
    a_init_exit: assert property (p_init_exit) else $error("init did not end"); // R17

    property p_deep_wake;
        st_q.mode == PM_DEEP && hit_c |=> power_mode == PM_SLEEP && !st_q.deep_req;
    endproperty
    a_deep_wake: assert property (p_deep_wake) else $error("deep doze not left"); // R17

    property p_drive_phase;
        sda_oe |-> st_q.phase inside {BS_AACK, BS_WACK, BS_RD, BS_RACK};
    endproperty
    a_drive_phase: assert property (p_drive_phase) else $error("pin driven in wrong phase"); // R1

    property p_stop_release;
        stop_c |=> st_q.phase == BS_IDLE && !sda_oe;
    endproperty
    a_stop_release: assert property (p_stop_release) else $error("stop did not release"); // R3

endmodule

`default_nettype wire

// ### rtl/fgm_pkg.sv
// Constants and types shared by the fuel gauge command map.
package fgm_pkg;

    // Standard command codes, the even code of each pair.
    localparam logic [7:0] CMD_CONTROL = 8'h00;
    localparam logic [7:0] CMD_TEMP    = 8'h02;
    localparam logic [7:0] CMD_CELL_POTENTIAL    = 8'h04;
    localparam logic [7:0] CMD_COND    = 8'h06;
    localparam logic [7:0] CMD_NOMAV   = 8'h08;
    localparam logic [7:0] CMD_FULAV   = 8'h0A;
    localparam logic [7:0] CMD_RMC     = 8'h0C;
    localparam logic [7:0] CMD_FULCH   = 8'h0E;
    localparam logic [7:0] CMD_MEANI   = 8'h10;
    localparam logic [7:0] CMD_STBYI   = 8'h12;
    localparam logic [7:0] CMD_MAXI    = 8'h14;
    localparam logic [7:0] CMD_ENERGY  = 8'h16;
    localparam logic [7:0] CMD_POWER   = 8'h18;
    localparam logic [7:0] CMD_CHARGE  = 8'h1C;
    localparam logic [7:0] CMD_INTMP   = 8'h1E;
    localparam logic [7:0] CMD_HEALTH  = 8'h20;

    // Control subcommands handled by this block.
    localparam logic [15:0] SUB_STATUS  = 16'h0000;
    localparam logic [15:0] SUB_PREV    = 16'h0007;
    localparam logic [15:0] SUB_DEEP    = 16'h0010;
    localparam logic [15:0] SUB_SET_HIB = 16'h0011;
    localparam logic [15:0] SUB_CLR_HIB = 16'h0012;
    localparam logic [15:0] SUB_RESTORE = 16'h0015;
    localparam logic [15:0] SUB_LOCK    = 16'h0020;
    localparam logic [15:0] SUB_RESET   = 16'h0041;

    // Bit positions in the control status word.
    localparam int ST_HIBE  = 15;
    localparam int ST_LOCK  = 13;
    localparam int ST_INIT  = 7;
    localparam int ST_HIB   = 6;
    localparam int ST_DEEP  = 5;
    localparam int ST_SLEEP = 4;

    // Misc constants.
    localparam logic [2:0] BIT_LAST      = 3'h7;
    localparam logic       LOCK_AT_RESET = 1'b1;
    localparam logic [6:0] DEV_ADDR_DEF  = 7'h55;

    typedef enum logic [2:0] {PM_INIT, PM_NORMAL, PM_SLEEP, PM_DEEP, PM_HIB} fgm_mode_t;
    typedef enum logic [2:0] {BS_IDLE, BS_ADDR, BS_AACK, BS_WR, BS_WACK, BS_RD, BS_RACK} fgm_bus_t;

    typedef struct packed {
        logic       scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
        fgm_bus_t   phase;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic       rw, hit, ack_drv, first;
        logic [7:0] ptr, wlo, wlo_ptr;
        logic       wlo_ok;
        logic [15:0] snap;
        logic [7:0] snap_ptr;
        logic       sda_o, sda_oe;
        logic [15:0] ctrl, prev;
        logic       stb;
        logic [15:0] host_temp, temp_out;
        logic       host_sel, locked, hib_req, deep_req;
        fgm_mode_t  mode;
    } fgm_state_t;

endpackage

// ### verif/fgm_host_model.sv
// Two-wire controller model standing in for the system host.
`timescale 1ns/1ps
`default_nettype none
module fgm_host_model (
    // Clock.
    input  wire logic mclk,
    // Wire levels.
    input  wire logic sda_line,
    output var  logic scl_o,
    output var  logic sda_low
);
    // The clock idles high and stands still between frames.
    initial begin
        scl_o = 1'b1;
        sda_low = 1'b0;
    end

    // Every change lands just after a clock edge.
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Low 600 ns, high 200 ns; read data is taken late in the high phase.
    task automatic bit_io(input logic b, output logic seen);
        wt(3);
        sda_low = !b;
        wt(3);
        scl_o = 1'b1;
        wt(2);
        seen = sda_line;
        scl_o = 1'b0;
    endtask

    // Start, also used as repeated start.
    task automatic start();
        sda_low = 1'b0;
        wt(3);
        scl_o = 1'b1;
        wt(4);
        sda_low = 1'b1;
        wt(4);
        scl_o = 1'b0;
    endtask

    task automatic stop();
        sda_low = 1'b1;
        wt(3);
        scl_o = 1'b1;
        wt(4);
        sda_low = 1'b0;
        wt(8);
    endtask

    // Code and data bytes go out MSB first, the ninth bit returns the answer.
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask

    // A released wire reads high through the pull-up.
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(last, s);
    endtask
endmodule
`default_nettype wire

// ### verif/fuel_gauge_standard_command_map_tb.sv
// Self-checking bench for the fuel gauge command map.
`timescale 1ns/1ps
`default_nettype none
module fuel_gauge_standard_command_map_tb;
    import fgm_pkg::*;
    logic        mclk, rst_b, scl, h_low, sda_o, sda_oe, stb;
    logic        init_done, sleep_cond, wake_evt, unlock_req, lock, hib;
    logic [15:0] m [14];
    logic [15:0] sub, tmp, d;
    fgm_mode_t   pm;
    int          err_total, cmp_count, stb_cnt, k;
    wire logic   sda = !(h_low || sda_oe);
    localparam logic [7:0] CODES [14] = '{CMD_CELL_POTENTIAL, CMD_COND, CMD_NOMAV, CMD_FULAV,
        CMD_RMC, CMD_FULCH, CMD_MEANI, CMD_STBYI, CMD_MAXI, CMD_ENERGY, CMD_POWER,
        CMD_CHARGE, CMD_INTMP, CMD_HEALTH};

    fgm_host_model host_u (.mclk(mclk), .sda_line(sda), .scl_o(scl), .sda_low(h_low));

    fgm_cmd_map dut_u (.mclk(mclk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .cell_potential_i(m[0]), .cond_i(m[1]), .nomav_i(m[2]),
        .fulav_i(m[3]), .rmc_i(m[4]), .fulch_i(m[5]), .meani_i(m[6]), .stbyi_i(m[7]),
        .maxi_i(m[8]), .energy_i(m[9]), .power_i(m[10]), .charge_i(m[11]),
        .intmp_i(m[12]), .health_i(m[13]), .init_done(init_done),
        .sleep_cond(sleep_cond), .wake_evt(wake_evt), .unlock_req(unlock_req),
        .subcmd(sub), .subcmd_stb(stb), .temp_used(tmp), .locked_state(lock),
        .hib_req(hib), .power_mode(pm));

    // Accepted control words are counted from the one-cycle strobe.
    always @(posedge mclk) begin
        if (stb === 1'b1) begin
            stb_cnt++;
        end
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Command code first, then low and high data byte in one stream.
    task automatic wr(input logic [7:0] c, input logic [15:0] v);
        logic a0, a1, a2, a3;
        host_u.start();
        host_u.wbyte({DEV_ADDR_DEF, 1'b0}, a0);
        host_u.wbyte(c, a1);
        host_u.wbyte(v[7:0], a2);
        host_u.wbyte(v[15:8], a3);
        host_u.stop();
        chk("write acks", {12'h0, a0, a1, a2, a3}, 16'h000F);
    endtask

    task automatic rd(input logic [7:0] c, output logic [15:0] v);
        logic a0, a1, a2;
        host_u.start();
        host_u.wbyte({DEV_ADDR_DEF, 1'b0}, a0);
        host_u.wbyte(c, a1);
        host_u.start();
        host_u.wbyte({DEV_ADDR_DEF, 1'b1}, a2);
        host_u.rbyte(1'b0, v[7:0]);
        host_u.rbyte(1'b1, v[15:8]);
        host_u.stop();
        chk("read acks", {13'h0, a0, a1, a2}, 16'h0007);
    endtask

    // Mode changes are given a bounded number of cycles.
    task automatic wait_mode(input fgm_mode_t e);
        for (k = 0; k < 60 && pm !== e; k++) begin
            @(posedge mclk);
            #1;
        end
        chk("power mode", {13'h0, pm}, {13'h0, e});
        if (pm !== e) begin
            tally_and_finish();
        end
    endtask

    task automatic pulse(ref logic s);
        @(posedge mclk);
        #1 s = 1'b1;
        @(posedge mclk);
        #1 s = 1'b0;
    endtask

    initial begin
        mclk = 1'b0;
        forever #50 mclk = !mclk;
    end

    initial begin
        repeat (100000) @(posedge mclk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        {rst_b, init_done, sleep_cond, wake_evt, unlock_req} = '0;
        {err_total, cmp_count, stb_cnt} = '0;
        for (int i = 0; i < 14; i++) begin
            m[i] = {8'hC0 + 8'(i), 8'h31 + 8'(i)};
        end
        repeat (16) @(posedge mclk);
        #1 rst_b = 1'b1;
        repeat (12) @(posedge mclk);
        chk("locked", {15'h0, lock}, 16'h0001);
        chk("subcmd", sub, 16'h0000);
        wait_mode(PM_INIT);
        rd(CMD_CELL_POTENTIAL, d);
        chk("read outside normal", d, 16'h0000);
        $display("test init done");
        init_done = 1'b1;
        wait_mode(PM_NORMAL);
        foreach (CODES[i]) begin
            rd(CODES[i], d);
            chk("measurement", d, m[i]);
        end
        $display("test map done");
        // Writes to a read-only word and to an unassigned pair change nothing.
        wr(CMD_CELL_POTENTIAL, 16'hFFFF);
        wr(8'h1A, 16'h1234);
        rd(CMD_CELL_POTENTIAL, d);
        chk("read-only word", d, m[0]);
        chk("no strobe", 16'(stb_cnt), 16'h0000);
        wr(CMD_TEMP, 16'h0BB8);
        chk("temp used", tmp, 16'h0BB8);
        rd(CMD_TEMP, d);
        chk("temp readback", d, 16'h0BB8);
        $display("test read-only and temperature done");
        wr(CMD_CONTROL, SUB_SET_HIB);
        chk("subcmd", sub, SUB_SET_HIB);
        chk("hib flag", {15'h0, hib}, 16'h0001);
        wr(CMD_CONTROL, SUB_RESET);
        chk("subcmd locked", sub, SUB_SET_HIB);
        wr(CMD_CONTROL, SUB_RESTORE);
        chk("restore locked", sub, SUB_SET_HIB);
        wr(CMD_CONTROL, SUB_STATUS);
        rd(CMD_CONTROL, d);
        chk("status", d & 16'hA0C0, 16'h20C0);
        chk("strobes", 16'(stb_cnt), 16'h0002);
        pulse(unlock_req);
        wr(CMD_CONTROL, SUB_RESET);
        chk("subcmd unlocked", sub, SUB_RESET);
        chk("locked", {15'h0, lock}, 16'h0000);
        $display("test control done");
        // Sleep with a pending hibernate request, then wake and return.
        sleep_cond = 1'b1;
        wait_mode(PM_HIB);
        pulse(wake_evt);
        wait_mode(PM_SLEEP);
        chk("hib flag", {15'h0, hib}, 16'h0000);
        sleep_cond = 1'b0;
        wait_mode(PM_NORMAL);
        $display("test power modes done");
        // Deep doze request, previous-subcommand readback, wake by traffic, relock.
        wr(CMD_CONTROL, SUB_DEEP);
        wr(CMD_CONTROL, SUB_PREV);
        rd(CMD_CONTROL, d);
        chk("previous subcmd", d, SUB_DEEP);
        sleep_cond = 1'b1;
        wait_mode(PM_DEEP);
        rd(CMD_CELL_POTENTIAL, d);
        chk("read in deep doze", d, 16'h0000);
        wait_mode(PM_SLEEP);
        sleep_cond = 1'b0;
        wait_mode(PM_NORMAL);
        wr(CMD_CONTROL, SUB_LOCK);
        chk("relocked", {15'h0, lock}, 16'h0001);
        wr(CMD_CONTROL, SUB_SET_HIB);
        wr(CMD_CONTROL, SUB_CLR_HIB);
        chk("hib cleared", {15'h0, hib}, 16'h0000);
        chk("sda out", {15'h0, sda_o}, 16'h0000);
        $display("test deep doze and lock done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
